// ### logic/sldc_host.sv
// host controller that drives the eight-way low-side driver serial link
// Overview of operation
// - each frame carries exactly eight bits
// - host makes the serial clock
// - serial clock low while select high
// - lead delay before first clock
// - lag delay after last falling clock
// - idle gap between two words
// - modulation rewrites at twice the rate
// - modulation no faster than 5 kHz at the default UPDATE_CYC; the bench's 200 gives 250 kHz
// - rewrite once every 100 us
`timescale 1ns/1ps
`include "sldc_consts.svh"

module sldc_host #(
	parameter int UPDATE_CYC = `SLDC_UPDATE_CYC
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic select_active_low,
	output logic sclk,
	output logic mosi,
	output logic first_driver_force_on
);

	localparam logic [7:0] LEAD_CYC = 8'(`SLDC_LEAD_CYC);
	localparam logic [7:0] HIGH_CYC = 8'(`SLDC_HIGH_CYC);
	localparam logic [7:0] LOW_CYC = 8'(`SLDC_LOW_CYC);
	localparam logic [7:0] LAG_CYC = 8'(`SLDC_LAG_CYC);
	localparam logic [7:0] GAP_CYC = 8'(`SLDC_GAP_CYC);
	localparam logic [15:0] UPD_LAST = 16'(UPDATE_CYC - 1);

	localparam sldc_pkg::sldc_main_t RST = '{
		state: sldc_pkg::ST_IDLE,
		bits: 3'h0,
		shreg: 8'h00,
		data: `SLDC_DATA_RST,
		mask: `SLDC_MASK_RST,
		sent: 8'h00,
		force_on: 1'b0,
		pwm_en: 1'b0,
		phase: 1'b0,
		pending: 1'b0,
		sel_n: 1'b1,
		sclk: 1'b0,
		mosi: 1'b0,
		pwm_cnt: 16'h0000,
		rdata: 32'h00000000
	};

	sldc_pkg::sldc_main_t r_reg;
	sldc_pkg::sldc_main_t r_next;

	sldc_tmr_if tif();

	logic load;
	logic [7:0] count;
	logic pwm_tick;
	logic take;

	sldc_timer u_tmr (
		.clk(clk),
		.reset_n(reset_n),
		.t(tif)
	);

	assign tif.load = load;
	assign tif.count = count;

	// rewrite strobe, one per interval while modulation runs
	assign pwm_tick = r_reg.pwm_en && (r_reg.pwm_cnt == 16'h0000);
	assign take = (r_reg.state == sldc_pkg::ST_IDLE) && r_reg.pending;

	always_comb begin
		logic [7:0] word;
		logic set_req;
		word = 8'h00;
		set_req = 1'b0;
		r_next = r_reg;
		load = 1'b0;
		count = 8'h00;

		// interval counter
		if (!r_reg.pwm_en || pwm_tick) begin
			r_next.pwm_cnt = UPD_LAST;
		end else begin
			r_next.pwm_cnt = r_reg.pwm_cnt - 16'h0001;
		end
		if (pwm_tick) begin
			r_next.phase = !r_reg.phase;
			set_req = 1'b1;
		end

		// register writes
		if (wr) begin
			case (addr)
				`SLDC_OFF_CTRL: begin
					r_next.force_on = wdata[`SLDC_CTRL_FORCE];
					r_next.pwm_en = wdata[`SLDC_CTRL_PWM];
				end
				`SLDC_OFF_DATA: begin
					r_next.data = wdata[7:0];
					set_req = 1'b1;
				end
				`SLDC_OFF_MASK: begin
					r_next.mask = wdata[7:0];
				end
				default: begin
				end
			endcase
		end

		// register reads, data stands one cycle
		r_next.rdata = 32'h00000000;
		if (rd) begin
			case (addr)
				`SLDC_OFF_CTRL: begin
					r_next.rdata[`SLDC_CTRL_FORCE] = r_reg.force_on;
					r_next.rdata[`SLDC_CTRL_PWM] = r_reg.pwm_en;
				end
				`SLDC_OFF_DATA: begin
					r_next.rdata[7:0] = r_reg.data;
				end
				`SLDC_OFF_MASK: begin
					r_next.rdata[7:0] = r_reg.mask;
				end
				`SLDC_OFF_STAT: begin
					r_next.rdata[`SLDC_STAT_BUSY] =
						(r_reg.state != sldc_pkg::ST_IDLE);
					r_next.rdata[`SLDC_STAT_PEND] = r_reg.pending;
					r_next.rdata[15:8] = r_reg.sent;
				end
				default: begin
				end
			endcase
		end

		// a new request wins over the clear by the take
		r_next.pending = set_req || (r_reg.pending && !take);

		// frame sequencer
		case (r_reg.state)
			sldc_pkg::ST_IDLE: begin
				r_next.sclk = 1'b0;
				if (r_reg.pending) begin
					word = r_reg.data;
					if (r_reg.pwm_en) begin
						word = (r_reg.data & ~r_reg.mask) |
							(r_reg.phase ? r_reg.mask : 8'h00);
					end
					r_next.sent = word;
					r_next.shreg = word;
					r_next.mosi = word[7];
					r_next.bits = 3'h7;
					r_next.sel_n = 1'b0;
					r_next.state = sldc_pkg::ST_LEAD;
					load = 1'b1;
					count = LEAD_CYC;
				end
			end
			sldc_pkg::ST_LEAD: begin
				if (tif.done) begin
					r_next.sclk = 1'b1;
					r_next.state = sldc_pkg::ST_HIGH;
					load = 1'b1;
					count = HIGH_CYC;
				end
			end
			sldc_pkg::ST_HIGH: begin
				if (tif.done) begin
					r_next.sclk = 1'b0;
					load = 1'b1;
					if (r_reg.bits == 3'h0) begin
						r_next.state = sldc_pkg::ST_LAG;
						count = LAG_CYC;
					end else begin
						r_next.state = sldc_pkg::ST_LOW;
						count = LOW_CYC;
						r_next.shreg = {r_reg.shreg[6:0], 1'b0};
						r_next.mosi = r_reg.shreg[6];
						r_next.bits = r_reg.bits - 3'h1;
					end
				end
			end
			sldc_pkg::ST_LOW: begin
				if (tif.done) begin
					r_next.sclk = 1'b1;
					r_next.state = sldc_pkg::ST_HIGH;
					load = 1'b1;
					count = HIGH_CYC;
				end
			end
			sldc_pkg::ST_LAG: begin
				if (tif.done) begin
					r_next.sel_n = 1'b1;
					r_next.state = sldc_pkg::ST_GAP;
					load = 1'b1;
					count = GAP_CYC;
				end
			end
			sldc_pkg::ST_GAP: begin
				if (tif.done) begin
					r_next.mosi = 1'b0;
					r_next.state = sldc_pkg::ST_IDLE;
				end
			end
			default: begin
				r_next.state = sldc_pkg::ST_IDLE;
				r_next.sel_n = 1'b1;
				r_next.sclk = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r_reg <= RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign rdata = r_reg.rdata;
	assign select_active_low = r_reg.sel_n;
	assign sclk = r_reg.sclk;
	assign mosi = r_reg.mosi;
	assign first_driver_force_on = r_reg.force_on;

	// checking helpers
	logic h_sclk_d;
	logic h_sel_d;
	logic h_upd_ok;
	logic [3:0] h_rises;
	logic [7:0] h_lag;
	logic [7:0] h_idle;
	logic [15:0] h_upd;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			h_sclk_d <= 1'b0;
			h_sel_d <= 1'b1;
			h_upd_ok <= 1'b0;
			h_rises <= 4'h0;
			h_lag <= 8'hFF;
			h_idle <= 8'hFF;
			h_upd <= 16'h0000;
		end else begin
			h_sclk_d <= r_reg.sclk;
			h_sel_d <= r_reg.sel_n;
			if (r_reg.sel_n) begin
				h_rises <= 4'h0;
			end else if (r_reg.sclk && !h_sclk_d) begin
				h_rises <= h_rises + 4'h1;
			end
			if (!r_reg.sclk && h_sclk_d) begin
				h_lag <= 8'h01;
			end else if (h_lag != 8'hFF) begin
				h_lag <= h_lag + 8'h01;
			end
			if (r_reg.sel_n && !h_sel_d) begin
				h_idle <= 8'h01;
			end else if (h_idle != 8'hFF) begin
				h_idle <= h_idle + 8'h01;
			end
			if (!r_reg.pwm_en) begin
				h_upd_ok <= 1'b0;
				h_upd <= 16'h0000;
			end else if (pwm_tick) begin
				h_upd_ok <= 1'b1;
				h_upd <= 16'h0000;
			end else begin
				h_upd <= h_upd + 16'h0001;
			end
		end
	end

	property p_sclk_idle_low;
		@(posedge clk) disable iff (!reset_n)
		r_reg.sel_n |-> !r_reg.sclk;
	endproperty
	a_sclk_idle_low: assert property (p_sclk_idle_low)
		else $error("serial clock high while select high");

	property p_lead;
		@(posedge clk) disable iff (!reset_n)
		$fell(r_reg.sel_n) |-> (!r_reg.sclk)[*8] ##1 r_reg.sclk;
	endproperty
	a_lead: assert property (p_lead)
		else $error("lead delay not eight cycles");

	property p_high_pulse;
		@(posedge clk) disable iff (!reset_n)
		$rose(r_reg.sclk) |-> r_reg.sclk[*6] ##1 !r_reg.sclk;
	endproperty
	a_high_pulse: assert property (p_high_pulse)
		else $error("serial clock high time wrong");

	property p_eight_bits;
		@(posedge clk) disable iff (!reset_n)
		$rose(r_reg.sel_n) |-> (h_rises == 4'h8);
	endproperty
	a_eight_bits: assert property (p_eight_bits)
		else $error("frame did not carry eight clocks");

	property p_msb_first;
		@(posedge clk) disable iff (!reset_n)
		$rose(r_reg.sclk) |->
			(r_reg.mosi == r_reg.sent[3'(4'h7 - h_rises)]);
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("data bit out of order");

	property p_lag;
		@(posedge clk) disable iff (!reset_n)
		$rose(r_reg.sel_n) |-> (h_lag >= LAG_CYC);
	endproperty
	a_lag: assert property (p_lag)
		else $error("select raised too soon after last clock");

	property p_gap;
		@(posedge clk) disable iff (!reset_n)
		$fell(r_reg.sel_n) |-> (h_idle >= GAP_CYC);
	endproperty
	a_gap: assert property (p_gap)
		else $error("gap between words too short");

	property p_pwm_rewrite;
		@(posedge clk) disable iff (!reset_n)
		pwm_tick |=> (r_reg.phase != $past(r_reg.phase)) && r_reg.pending;
	endproperty
	a_pwm_rewrite: assert property (p_pwm_rewrite)
		else $error("rewrite did not toggle phase and queue a word");

	property p_pwm_spacing;
		@(posedge clk) disable iff (!reset_n)
		pwm_tick |=> (!pwm_tick)[*8];
	endproperty
	a_pwm_spacing: assert property (p_pwm_spacing)
		else $error("rewrites closer than allowed");

	property p_pwm_interval;
		@(posedge clk) disable iff (!reset_n)
		(pwm_tick && h_upd_ok) |-> (h_upd == UPD_LAST);
	endproperty
	a_pwm_interval: assert property (p_pwm_interval)
		else $error("rewrite interval wrong");

endmodule

// ### logic/sldc_timer.sv
// interval timer: done marks the last cycle of a loaded span
`timescale 1ns/1ps
`include "sldc_consts.svh"

module sldc_timer (
	input wire logic clk,
	input wire logic reset_n,
	sldc_tmr_if.tmr t
);

	sldc_pkg::sldc_tmr_t r_reg;
	sldc_pkg::sldc_tmr_t r_next;

	always_comb begin
		r_next = r_reg;
		if (t.load) begin
			r_next.cnt = t.count;
		end else if (r_reg.cnt != 8'h00) begin
			r_next.cnt = r_reg.cnt - 8'h01;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign t.done = (r_reg.cnt == 8'h01);

endmodule

// ### shared/sldc_consts.svh
// offsets, fields, reset values and timing counts of the driver link host
`ifndef SLDC_CONSTS_SVH
`define SLDC_CONSTS_SVH

`define SLDC_CLK_NS 10
`define SLDC_T1_LEAD_NS 10
`define SLDC_T2_LEAD_NS 80
`define SLDC_HIGH_NS 60
`define SLDC_LOW_NS 60
`define SLDC_LAG_NS 80
`define SLDC_GAP_NS 170
`define SLDC_UPDATE_NS 100000

// least times, rounded up to whole cycles
`define SLDC_LEAD_CYC ((`SLDC_T2_LEAD_NS + `SLDC_CLK_NS - 1) / `SLDC_CLK_NS)
`define SLDC_HIGH_CYC ((`SLDC_HIGH_NS + `SLDC_CLK_NS - 1) / `SLDC_CLK_NS)
`define SLDC_LOW_CYC ((`SLDC_LOW_NS + `SLDC_CLK_NS - 1) / `SLDC_CLK_NS)
`define SLDC_LAG_CYC ((`SLDC_LAG_NS + `SLDC_CLK_NS - 1) / `SLDC_CLK_NS)
`define SLDC_GAP_CYC ((`SLDC_GAP_NS + `SLDC_CLK_NS - 1) / `SLDC_CLK_NS)
// fixed rewrite interval
`define SLDC_UPDATE_CYC (`SLDC_UPDATE_NS / `SLDC_CLK_NS)

`define SLDC_WORD_BITS 8
`define SLDC_CNT_W 8
`define SLDC_PWM_W 16

`define SLDC_OFF_CTRL 8'h00
`define SLDC_OFF_DATA 8'h04
`define SLDC_OFF_MASK 8'h08
`define SLDC_OFF_STAT 8'h0C

`define SLDC_CTRL_FORCE 0
`define SLDC_CTRL_PWM 1
`define SLDC_STAT_BUSY 0
`define SLDC_STAT_PEND 1

`define SLDC_DATA_RST 8'h00
`define SLDC_MASK_RST 8'h00

`endif

// ### shared/sldc_pkg.sv
// types of the driver link host
package sldc_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_LEAD = 3'h1,
		ST_HIGH = 3'h2,
		ST_LOW = 3'h3,
		ST_LAG = 3'h4,
		ST_GAP = 3'h5
	} sldc_state_t;

	typedef struct packed {
		sldc_state_t state;
		logic [2:0] bits;
		logic [7:0] shreg;
		logic [7:0] data;
		logic [7:0] mask;
		logic [7:0] sent;
		logic force_on;
		logic pwm_en;
		logic phase;
		logic pending;
		logic sel_n;
		logic sclk;
		logic mosi;
		logic [15:0] pwm_cnt;
		logic [31:0] rdata;
	} sldc_main_t;

	typedef struct packed {
		logic [7:0] cnt;
	} sldc_tmr_t;

endpackage

// ### shared/sldc_tmr_if.sv
// link between the sequencer and its interval timer
`timescale 1ns/1ps
`include "sldc_consts.svh"

interface sldc_tmr_if;
	logic load;
	logic [`SLDC_CNT_W-1:0] count;
	logic done;

	modport ctl (output load, output count, input done);
	modport tmr (input load, input count, output done);
endinterface

// ### tb/sldc_dev_model.sv
// behavioural model of the eight-way low-side driver device
`timescale 1ns/1ps
module sldc_dev_model (
	input wire logic select_active_low,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic first_driver_force_on,
	output logic [7:0] driver_output_control,
	output logic [7:0] low_side_drivers,
	output int load_cnt,
	output int viol_cnt
);
	logic [7:0] shreg;
	int bits;
	realtime t_fall;
	realtime t_rise;
	realtime t_last;
	initial begin
		driver_output_control = 8'h00;
		shreg = 8'h00;
		bits = 0;
		load_cnt = 0;
		viol_cnt = 0;
		t_rise = -1000.0;
		t_fall = 0.0;
		t_last = 0.0;
	end
	// shift only on the host clock while selected
	always @(posedge sclk) begin
		if (select_active_low) begin
			viol_cnt++;
		end else begin
			if (bits == 0 && $realtime - t_fall < 10.0) viol_cnt++;
			shreg = {shreg[6:0], mosi};
			bits++;
		end
	end
	always @(negedge sclk) t_last = $realtime;
	always @(negedge select_active_low) begin
		if ($realtime - t_rise < 170.0) viol_cnt++;
		t_fall = $realtime;
		bits = 0;
	end
	// whole word loads on select rise, short word dropped
	always @(posedge select_active_low) begin
		t_rise = $realtime;
		if (bits > 0 && (sclk || $realtime - t_last < 80.0)) viol_cnt++;
		if (bits == 8) begin
			driver_output_control = shreg;
			load_cnt++;
		end
	end
	assign low_side_drivers = {driver_output_control[7:1],
		driver_output_control[0] | first_driver_force_on};
endmodule

// ### tb/sldc_host_tb_top.sv
// self-checking bench for the driver link host
`timescale 1ns/1ps
`include "sldc_consts.svh"
module sldc_host_tb_top;
	localparam int UPD = 200;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic sel_n;
	logic sclk;
	logic mosi;
	logic force_on;
	logic [7:0] ocr;
	logic [7:0] drv;
	int loads;
	int viols;
	int error_cnt = 0;
	int total_checks = 0;
	always #5 clk = ~clk;
	sldc_host #(.UPDATE_CYC(UPD)) dut (.clk(clk), .reset_n(reset_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.select_active_low(sel_n), .sclk(sclk), .mosi(mosi),
		.first_driver_force_on(force_on));
	sldc_dev_model dev (.select_active_low(sel_n), .sclk(sclk),
		.mosi(mosi), .first_driver_force_on(force_on),
		.driver_output_control(ocr), .low_side_drivers(drv),
		.load_cnt(loads), .viol_cnt(viols));
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic wait_idle();
		logic [31:0] s;
		int n;
		n = 0;
		s = 32'h3;
		while (s[1:0] !== 2'h0 && n < 300) begin
			rd_reg(`SLDC_OFF_STAT, s);
			n++;
		end
		chk("idle", 32'h0, {30'h0, s[1:0]});
	endtask
	task automatic wait_load(output logic [7:0] v, output realtime t);
		int n;
		n = loads;
		for (int i = 0; i < 400 && loads == n; i++) @(posedge clk);
		chk("load seen", 32'h1, {31'h0, loads != n});
		v = ocr;
		t = $realtime;
	endtask
	task automatic t_reset();
		logic [31:0] d;
		logic [7:0] a [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
		chk("pins", 32'h8, {28'h0, sel_n, sclk, force_on, mosi});
		chk("device word", 32'h0, {24'h0, ocr});
		foreach (a[i]) begin
			rd_reg(a[i], d);
			chk("reset read", 32'h0, d);
		end
		$display("test reset done");
	endtask
	task automatic t_frame();
		logic [31:0] d;
		int n;
		n = loads;
		wr_reg(`SLDC_OFF_DATA, 32'hA5);
		wait_idle();
		chk("word", 32'hA5, {24'h0, ocr});
		chk("frames", 32'h1, 32'(loads - n));
		rd_reg(`SLDC_OFF_STAT, d);
		chk("sent", 32'hA5, {24'h0, d[15:8]});
		$display("test frame done");
	endtask
	task automatic t_b2b();
		int n;
		n = loads;
		wr_reg(`SLDC_OFF_DATA, 32'h3C);
		wr_reg(`SLDC_OFF_DATA, 32'hC3);
		wait_idle();
		chk("frames", 32'h2, 32'(loads - n));
		chk("word", 32'hC3, {24'h0, ocr});
		$display("test back to back done");
	endtask
	task automatic t_force();
		wr_reg(`SLDC_OFF_DATA, 32'h02);
		wait_idle();
		wr_reg(`SLDC_OFF_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		chk("forced", 32'h03, {24'h0, drv});
		wr_reg(`SLDC_OFF_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		chk("released", 32'h02, {24'h0, drv});
		$display("test force done");
	endtask
	task automatic t_pwm();
		logic [7:0] v1;
		logic [7:0] v2;
		realtime t1;
		realtime t2;
		wr_reg(`SLDC_OFF_MASK, 32'h01);
		wr_reg(`SLDC_OFF_DATA, 32'h80);
		wait_idle();
		wr_reg(`SLDC_OFF_CTRL, 32'h2);
		wait_load(v1, t1);
		wait_load(v2, t2);
		chk("toggle", 32'h01, {24'h0, v1 ^ v2});
		chk("kept", 32'h40, {25'h0, v2[7:1]});
		chk("interval", 32'(UPD * 10), 32'(int'(t2 - t1)));
		wr_reg(`SLDC_OFF_CTRL, 32'h0);
		wait_idle();
		$display("test modulation done");
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_frame();
		t_b2b();
		t_force();
		t_pwm();
		chk("link timing", 32'h0, 32'(viols));
		give_verdict();
	end
	initial begin
		#(20000 * 10);
		error_cnt++;
		give_verdict();
	end
endmodule
